//--- src/tvdac_input_latch.sv
`timescale 1ns/1ps
`default_nettype none

module tvdac_input_latch
#(
   parameter logic LOW_POWER_REQUEST_ACTIVE = tvdac_pkg::TVDAC_LOW_POWER_REQUEST_ACTIVE
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire tvdac_pkg::tvdac_word_t red_pixel_bits,
   input  wire tvdac_pkg::tvdac_word_t green_pixel_bits,
   input  wire tvdac_pkg::tvdac_word_t blue_pixel_bits,
   input  wire logic                  blank_n,
   input  wire logic                  sync_n,
   input  wire logic                  low_power_request,
   output var  tvdac_pkg::tvdac_word_t red_current_out,
   output var  tvdac_pkg::tvdac_word_t green_current_out,
   output var  tvdac_pkg::tvdac_word_t blue_current_out,
   output var  logic                  green_sync_on,
   output var  logic                  blanked,
   output var  logic                  low_power
);
   import tvdac_pkg::*;

   tvdac_pixel_s capture;
   tvdac_pixel_s pipe [TVDAC_DEPTH];
   tvdac_drive_s drive_q;
   tvdac_drive_s drive_d;

   // The colour, blank and sync inputs enter together on the same edge; bit order is kept as wired.
   always_comb
   begin
      capture.red     = red_pixel_bits;
      capture.green   = green_pixel_bits;
      capture.blue    = blue_pixel_bits;
      capture.blank_n = blank_n;
      capture.sync_n  = sync_n;
   end

   // The first stage is the input capture; the rest only add latency.
   // Controls ride in the same stage word as the colours, so a deeper pipe cannot skew them.
   // A depth change moves every pixel-path delay, but the assertions below hard-code three edges; the one-edge power-save delays stay put.
   generate
      for (genvar i = 0; i < TVDAC_DEPTH; i++)
      begin : g_pipe
         if (i == 0)
         begin : g_first
            tvdac_stage u_tvdac_stage
            (
               .clk     (clk),
               .rst     (rst),
               .pix_in  (capture),
               .pix_out (pipe[0])
            );
         end
         else
         begin : g_next
            tvdac_stage u_tvdac_stage
            (
               .clk     (clk),
               .rst     (rst),
               .pix_in  (pipe[i-1]),
               .pix_out (pipe[i])
            );
         end
      end
   endgenerate

   // Blanking masks data; sync only gates the green pedestal source and never touches the codes.
   // The power-save request skips the pipeline on purpose: it has no pixel to stay aligned with.
   // The limitation is that a request lands on the outputs two edges before the pixels around it.
   always_comb
   begin
      drive_d           = drive_q;
      drive_d.blanked   = !pipe[TVDAC_DEPTH-1].blank_n;
      drive_d.low_power = (low_power_request == LOW_POWER_REQUEST_ACTIVE);
      if (!pipe[TVDAC_DEPTH-1].blank_n)
      begin
         drive_d.red_code   = TVDAC_BLANK_CODE;
         drive_d.green_code = TVDAC_BLANK_CODE;
         drive_d.blue_code  = TVDAC_BLANK_CODE;
      end
      else
      begin
         drive_d.red_code   = pipe[TVDAC_DEPTH-1].red;
         drive_d.green_code = pipe[TVDAC_DEPTH-1].green;
         drive_d.blue_code  = pipe[TVDAC_DEPTH-1].blue;
      end
      // Sync low switches the source off regardless of blank; the controller keeps them ordered.
      drive_d.green_sync_on = pipe[TVDAC_DEPTH-1].sync_n;
   end

   // Output register; a sync reset leaves the outputs blanked with sync current off.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         drive_q           <= '0;
         drive_q.blanked   <= 1'b1;
      end
      else
      begin
         drive_q <= drive_d;
      end
   end

   // Every output comes straight from the output register, so the converters see no logic glitches.
   assign red_current_out   = drive_q.red_code;
   assign green_current_out = drive_q.green_code;
   assign blue_current_out  = drive_q.blue_code;
   assign green_sync_on     = drive_q.green_sync_on;
   assign blanked           = drive_q.blanked;
   assign low_power         = drive_q.low_power;

   // Total latency from an input edge to the outputs is the pipeline plus the output register.
   // With two stages that makes three edges, which is the fixed delay used by the pixel and control checks below.
   // Reset disables the checks other than a_reset_blanks, since the reset values of the stages are not real pixels.
   sequence s_blank_in;
      !blank_n;
   endsequence

   sequence s_codes_zero;
      red_current_out == TVDAC_BLANK_CODE && green_current_out == TVDAC_BLANK_CODE
         && blue_current_out == TVDAC_BLANK_CODE && blanked;
   endsequence

   a_blank_masks_data : assert property (@(posedge clk) disable iff (rst)
      s_blank_in |-> ##3 s_codes_zero)
      else $error("blank low did not zero the outputs");

   a_blank_ignores_pix : assert property (@(posedge clk) disable iff (rst)
      ##3 blanked |-> (red_current_out | green_current_out | blue_current_out) == 8'h00)
      else $error("pixel data leaked while blanked");

   a_red_data_path : assert property (@(posedge clk) disable iff (rst)
      blank_n |-> ##3 (red_current_out == $past(red_pixel_bits, 3)))
      else $error("red word not presented after capture");

   a_green_blue_path : assert property (@(posedge clk) disable iff (rst)
      blank_n |-> ##3 (green_current_out == $past(green_pixel_bits, 3)
         && blue_current_out == $past(blue_pixel_bits, 3)))
      else $error("green or blue word misordered");

   a_blank_sampled : assert property (@(posedge clk) disable iff (rst)
      blank_n |-> ##3 !blanked)
      else $error("blank high not seen at output");

   a_sync_green_src : assert property (@(posedge clk) disable iff (rst)
      ##3 (green_sync_on == $past(sync_n, 3)))
      else $error("green sync source not following sync");

   a_sync_no_override : assert property (@(posedge clk) disable iff (rst)
      (!sync_n && blank_n) |-> ##3 (!green_sync_on && !blanked
         && green_current_out == $past(green_pixel_bits, 3)))
      else $error("sync disturbed blank or data");

   a_power_save : assert property (@(posedge clk) disable iff (rst)
      (low_power_request == LOW_POWER_REQUEST_ACTIVE) |=> low_power)
      else $error("power save not entered");

   a_ctl_aligned : assert property (@(posedge clk) disable iff (rst)
      (blank_n && !sync_n) ##1 (!blank_n) |-> ##2 (!green_sync_on && !blanked) ##1 blanked)
      else $error("controls misaligned with data");

   // A pixel that the controller leaves unblanked with sync released.
   sequence s_active_pixel;
      blank_n && sync_n;
   endsequence

   // Two blanked inputs back to back, as at the start of a retrace.
   sequence s_blank_pair;
      !blank_n ##1 !blank_n;
   endsequence

   // The output side of a blanked pair, three edges behind the inputs.
   sequence s_blanked_pair;
      blanked ##1 blanked;
   endsequence

   // A legal sync, low inside blanking.
   sequence s_legal_sync;
      !sync_n && !blank_n;
   endsequence

   // Reset forces the blanked state on the next edge, so a monitor never sees stale colour after a restart.
   a_reset_blanks : assert property (@(posedge clk)
      rst |=> (s_codes_zero and !green_sync_on and !low_power))
      else $error("reset did not leave the outputs blanked");

   // Sync released on an active pixel turns the green source back on.
   a_green_src_on : assert property (@(posedge clk) disable iff (rst)
      s_active_pixel |-> ##3 (green_sync_on && !blanked))
      else $error("green source not restored");

   // A run of blanked inputs gives an equally long run of blanked outputs.
   a_blank_run : assert property (@(posedge clk) disable iff (rst)
      s_blank_pair |-> ##2 s_blanked_pair)
      else $error("blank run shortened on the way through");

   // A sync inside blanking turns the green source off and keeps the codes at blank.
   a_sync_in_blank : assert property (@(posedge clk) disable iff (rst)
      s_legal_sync |-> ##3 (s_codes_zero and !green_sync_on))
      else $error("sync during blanking not applied");

   // Dropping the request leaves reduced power one edge later.
   a_power_exit : assert property (@(posedge clk) disable iff (rst)
      (low_power_request != LOW_POWER_REQUEST_ACTIVE) |=> !low_power)
      else $error("power save not left");

   // One end bit of each colour (bit 0 of red and blue, bit 7 of green) is checked on its own, so a reversed bus shows by name.
   a_bit_order : assert property (@(posedge clk) disable iff (rst)
      blank_n |-> ##3 (red_current_out[0] == $past(red_pixel_bits[0], 3)
         && green_current_out[7] == $past(green_pixel_bits[7], 3)
         && blue_current_out[0] == $past(blue_pixel_bits[0], 3)))
      else $error("colour bit order reversed");

endmodule

`default_nettype wire

//--- src/tvdac_pkg.sv
package tvdac_pkg;

   // Width of one colour word.
   localparam int unsigned TVDAC_BITS = 8;
   // Pipeline stages from the input capture to the converter outputs.
   localparam int unsigned TVDAC_DEPTH = 2;
   // Default active level of the power-save request.
   localparam logic TVDAC_LOW_POWER_REQUEST_ACTIVE = 1'b1;
   // Converter code driven while blanking; the blanking level is code zero, with the green sync current still following sync.
   localparam logic [7:0] TVDAC_BLANK_CODE = 8'h00;
   // Reset value of the captured active-low controls: blanked, sync current off.
   localparam logic TVDAC_CTL_RESET = 1'b0;

   typedef logic [TVDAC_BITS-1:0] tvdac_word_t;

   // One captured pixel with its controls, carried through the pipeline as one unit.
   typedef struct packed
   {
      tvdac_word_t red;
      tvdac_word_t green;
      tvdac_word_t blue;
      logic        blank_n;
      logic        sync_n;
   } tvdac_pixel_s;

   // Drive to the three current outputs.
   typedef struct packed
   {
      tvdac_word_t red_code;
      tvdac_word_t green_code;
      tvdac_word_t blue_code;
      logic        green_sync_on;
      logic        blanked;
      logic        low_power;
   } tvdac_drive_s;

endpackage

//--- src/tvdac_stage.sv
`timescale 1ns/1ps
`default_nettype none

// One pipeline register for a captured pixel with its controls.
module tvdac_stage
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire tvdac_pkg::tvdac_pixel_s pix_in,
   output var  tvdac_pkg::tvdac_pixel_s pix_out
);
   import tvdac_pkg::*;

   tvdac_pixel_s stage_q;
   tvdac_pixel_s stage_d;

   // Controls travel in the same word as the data so they cannot skew.
   always_comb
   begin
      stage_d = pix_in;
   end

   // Reset clears the data to zero and the controls to a blanked state; data is passed on otherwise.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stage_q         <= '0;
         stage_q.blank_n <= TVDAC_CTL_RESET;
         stage_q.sync_n  <= TVDAC_CTL_RESET;
      end
      else
      begin
         stage_q <= stage_d;
      end
   end

   assign pix_out = stage_q;

endmodule

`default_nettype wire

//--- sim/tvdac_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// Graphics controller on the far side: passes the requested pixel and controls to the device pins.
module tvdac_ctrl_model
(
   input  wire tvdac_pkg::tvdac_pixel_s req,
   input  wire logic                    sync_tied_low,
   output var  tvdac_pkg::tvdac_pixel_s pix
);
   import tvdac_pkg::*;

   // Sync is held high outside blanking, because the device does not stop a stray sync.
   // A board without sync on green ties the pin low instead, whatever the blanking does.
   always_comb
   begin
      pix = req;
      if (sync_tied_low)
      begin
         pix.sync_n = 1'b0;
      end
      else
      begin
         pix.sync_n = req.sync_n | req.blank_n;
      end
   end
endmodule

`default_nettype wire

//--- sim/test_triple_video_dac_input_latch.sv
`timescale 1ns/1ps
`default_nettype none

module test_triple_video_dac_input_latch;
   import tvdac_pkg::*;

   logic         clk;
   logic         rst;
   logic         lp_req;
   logic         tie_sync;
   tvdac_pixel_s req;
   tvdac_pixel_s pix;
   tvdac_drive_s seen;
   tvdac_pixel_s tbl [6];
   int           bad_count;
   int           check_count;

   tvdac_ctrl_model u_tvdac_ctrl_model (.req(req), .sync_tied_low(tie_sync), .pix(pix));

   tvdac_input_latch u_tvdac_input_latch
   (
      .clk(clk), .rst(rst), .red_pixel_bits(pix.red), .green_pixel_bits(pix.green),
      .blue_pixel_bits(pix.blue), .blank_n(pix.blank_n), .sync_n(pix.sync_n),
      .low_power_request(lp_req), .red_current_out(seen.red_code),
      .green_current_out(seen.green_code), .blue_current_out(seen.blue_code),
      .green_sync_on(seen.green_sync_on), .blanked(seen.blanked), .low_power(seen.low_power)
   );

   // Free-running pixel clock at 40 MHz.
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Compares one observed value with its expectation and counts the result.
   task automatic check(input string name, input logic [26:0] got, input logic [26:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Expected drive for a captured pixel; blanking masks every colour word.
   function automatic tvdac_drive_s expect_drive(input tvdac_pixel_s p);
      expect_drive.red_code      = p.blank_n ? p.red : 8'h00;
      expect_drive.green_code    = p.blank_n ? p.green : 8'h00;
      expect_drive.blue_code     = p.blank_n ? p.blue : 8'h00;
      expect_drive.green_sync_on = p.sync_n;
      expect_drive.blanked       = ~p.blank_n;
      expect_drive.low_power     = 1'b0;
   endfunction

   // Back-to-back pixels, each output checked three edges after its capture edge.
   // The first three outputs still come from blanked pixels: reset values or the last stream's tail.
   task automatic stream_check(input logic tie);
      tvdac_pixel_s e;
      tie_sync = tie;
      for (int i = 0; i < 9; i++)
      begin
         @(negedge clk);
         req = (i < 6) ? tbl[i] : tbl[2];
         if (i < 3)
            check("flush", seen, 27'h000_0002);
         else
         begin
            e        = tbl[i-3];
            e.sync_n = tie ? 1'b0 : (e.sync_n | e.blank_n);
            check("stream", seen, expect_drive(e));
         end
      end
   endtask

   // The power-save request shows one edge later and clears the same way.
   task automatic power_check();
      @(negedge clk);
      lp_req = 1'b1;
      @(negedge clk);
      check("low_power", {26'h000_0000, seen.low_power}, 27'h000_0001);
      lp_req = 1'b0;
      @(negedge clk);
      check("low_power", {26'h000_0000, seen.low_power}, 27'h000_0000);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Main sequence: reset, pixel stream with blanking and sync, again with sync tied low, then power save.
   initial
   begin
      bad_count   = 0;
      check_count = 0;
      rst         = 1'b1;
      lp_req      = 1'b0;
      tie_sync    = 1'b0;
      req         = '0;
      tbl[0] = '{red: 8'h12, green: 8'h34, blue: 8'h56, blank_n: 1'b1, sync_n: 1'b1};
      tbl[1] = '{red: 8'h80, green: 8'h01, blue: 8'hFF, blank_n: 1'b1, sync_n: 1'b1};
      tbl[2] = '{red: 8'hAA, green: 8'h55, blue: 8'hC3, blank_n: 1'b0, sync_n: 1'b0};
      tbl[3] = '{red: 8'hAA, green: 8'h55, blue: 8'hC3, blank_n: 1'b0, sync_n: 1'b1};
      tbl[4] = '{red: 8'hFF, green: 8'hFF, blue: 8'hFF, blank_n: 1'b1, sync_n: 1'b1};
      tbl[5] = '{red: 8'h01, green: 8'h80, blue: 8'h7E, blank_n: 1'b1, sync_n: 1'b0};
      repeat (2) @(negedge clk);
      check("reset", seen, 27'h000_0002);
      rst = 1'b0;
      stream_check(1'b0);
      stream_check(1'b1);
      power_check();
      final_report();
   end
endmodule

`default_nettype wire
